// file: hdl/tx_pkg.sv
// Purpose: Shared constants and carriers for the transmit align/encode channel.
// Assumes: One channel per instance; registers reached over AXI4-Lite.
// Notes:   Symbols are tagged words: class in the top two bits, value below.
package tx_pkg;

    // ----------------------------------------------------------------------
    // Bus and register map
    // ----------------------------------------------------------------------
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;
    localparam int         STRB_W        = 4;
    localparam logic [7:0] CTRL_ADDR     = 8'h00;
    localparam logic [7:0] STATUS_ADDR   = 8'h04;
    localparam logic [7:0] PHASE_ADDR    = 8'h08;
    localparam int         CTRL_ENC_BIT  = 0;
    localparam int         CTRL_BIST_BIT = 1;
    localparam logic       CTRL_ENC_RST  = 1'b1;
    localparam logic       CTRL_BIST_RST = 1'b0;
    localparam int         ST_FAULT_BIT  = 0;
    localparam int         ST_WSYNC_BIT  = 1;
    localparam int         ST_READY_BIT  = 2;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // ----------------------------------------------------------------------
    // Character layout and codes
    // ----------------------------------------------------------------------
    localparam int         RAW_W       = 10;
    localparam int         CTL_LSB     = 8;
    localparam logic [1:0] CTL_DATA    = 2'h0;
    localparam logic [1:0] CTL_FILL    = 2'h1;
    localparam logic [1:0] CTL_SPECIAL = 2'h2;
    localparam logic [1:0] CTL_WSYNC   = 2'h3;
    localparam logic [1:0] CLS_DATA    = 2'h0;
    localparam logic [1:0] CLS_SPECIAL = 2'h1;
    localparam logic [1:0] CLS_VIOL    = 2'h2;
    localparam logic [9:0] COMMA_SYM   = {CLS_SPECIAL, 8'hbc};
    localparam logic [9:0] VIOL_SYM    = {CLS_VIOL, 8'he0};
    localparam logic [3:0] WSYNC_FIRST = 4'h1;
    localparam logic [3:0] WSYNC_LAST  = 4'hf;
    localparam int         LFSR_W      = 9;
    localparam int         LFSR_TAP    = 4;
    localparam logic [8:0] LFSR_SEED   = 9'h1ff;

    // ----------------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------------
    typedef enum logic [2:0] {
        BUF_INIT  = 3'b001,
        BUF_RUN   = 3'b010,
        BUF_FAULT = 3'b100
    } buf_state_type;

    typedef struct packed {
        logic              rst_n;
        logic              in_clk;
        logic              ref_clk;
        logic [RAW_W-1:0]  raw;
    } pin_bundle_type;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } axi_req_type;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } axi_rsp_type;

endpackage

// file: hdl/pin_sync.sv
// Purpose: Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes: Bits are sampled independently; bundles must be stable near edges.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [W-1:0] pins_in,
    output logic      [W-1:0] pins_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta     <= '0;
            pins_out <= '0;
        end else begin
            meta     <= pins_in;
            pins_out <= meta;
        end
    end
endmodule

// file: hdl/tx_symbol_encoder.sv
// Purpose: Pick the outgoing transmission symbol for one character slot.
// Assumes: Code tables sit downstream; symbols here are class-tagged values.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module tx_symbol_encoder (
    input  wire logic                   enc_en_in,
    input  wire logic                   fault_in,
    input  wire logic                   bist_in,
    input  wire logic                   fill_in,
    input  wire logic [tx_pkg::RAW_W-1:0]  raw_in,
    input  wire logic [tx_pkg::LFSR_W-1:0] bist_word_in,
    output logic      [tx_pkg::RAW_W-1:0]  symbol_out
);
    import tx_pkg::*;

    always_comb begin
        if (fault_in) begin
            symbol_out = VIOL_SYM;
        end else if (bist_in) begin
            symbol_out = {1'b0, bist_word_in};
        end else if (fill_in) begin
            symbol_out = COMMA_SYM;
        end else if (!enc_en_in) begin
            symbol_out = raw_in;
        end else begin
            case (raw_in[RAW_W-1:CTL_LSB])
                CTL_DATA: begin
                    symbol_out = {CLS_DATA, raw_in[CTL_LSB-1:0]};
                end
                CTL_SPECIAL: begin
                    symbol_out = {CLS_SPECIAL, raw_in[CTL_LSB-1:0]};
                end
                default: begin
                    symbol_out = COMMA_SYM;
                end
            endcase
        end
    end
endmodule

// file: hdl/tx_align_encode.sv
// Purpose: Transmit front end of one channel: capture, phase align, encode.
// Assumes: clk_in at 250 MHz oversamples the input and reference clocks.
// Notes:   Instantiate once per channel; channels share nothing.
//
// What this block does
// - Capture eight character and two control bits each rising input edge
// - Bypass passes all ten bits unchanged, control on top
// - Shift each symbol out least significant bit first
// - Encoding uses control bits to choose the symbol
// - Characters cross through a phase-align buffer
// - Reset sampled low initialises the buffer
// - Reset release records input phase as centre
// - Reset is synchronised before any logic uses it
// - Drift within half a character is tolerated
// - Excess skew sets a sticky fault until reset or word sync
// - Fault sends violation symbols instead of data
// - Word sync during fault recentres and clears fault
// - Buffer reset may insert comma fill only
// - Encoder emits raw, data or special symbol
// - Buffer overflow or underflow forces violation symbol
// - Self-test sends pseudo-random pattern instead of host
// - Comma emitted singly or within word sync
// - Control pair selects data, fill, special, sync
// - Word sync runs sixteen commas, input ignored
`timescale 1ns/1ps
module tx_align_encode #(
    parameter int PHASE_W = 8
) (
    input  wire logic                      clk_in,
    input  wire logic                      sys_rst_in,
    input  wire logic                      tx_input_clock_in,
    input  wire logic                      char_ref_clock_in,
    input  wire logic                      tx_path_reset_n_in,
    input  wire logic [7:0]                tx_char_in,
    input  wire logic [1:0]                tx_ctl_in,
    input  wire tx_pkg::axi_req_type       axi_in,
    output tx_pkg::axi_rsp_type            axi_out,
    output logic [tx_pkg::RAW_W-1:0]       tx_symbol_out,
    output logic                           tx_serial_out,
    output logic                           tx_fault_flag_out,
    output logic                           tx_wsync_active_out
);
    import tx_pkg::*;

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic                       in_clk_d;
        logic                       ref_d;
        logic [RAW_W-1:0]           din_d;
        logic [RAW_W-1:0]           hold;
        logic [RAW_W-1:0]           buf_word;
        logic                       buf_full;
        buf_state_type              bstate;
        logic [PHASE_W-1:0]         ref_phase;
        logic [PHASE_W-1:0]         ref_period;
        logic [PHASE_W-1:0]         centre;
        logic [PHASE_W-1:0]         last_phase;
        logic signed [PHASE_W+1:0]  drift;
        logic                       tx_fault;
        logic                       ws_on;
        logic [3:0]                 ws_cnt;
        logic [LFSR_W-1:0]          lfsr;
        logic [RAW_W-1:0]           sym;
        logic [RAW_W-1:0]           shift;
        logic                       serial;
        logic                       enc_en;
        logic                       bist_en;
        logic                       aw_got;
        logic [ADDR_W-1:0]          aw_addr;
        logic                       w_got;
        logic [DATA_W-1:0]          wdata;
        logic [STRB_W-1:0]          wstrb;
        axi_rsp_type                rsp;
    } main_state_type;

    main_state_type             st;
    main_state_type             nx;
    pin_bundle_type             pins;
    pin_bundle_type             sy;
    logic                       in_edge;
    logic                       ref_edge;
    logic                       fault_now;
    logic                       ws_req;
    logic                       over;
    logic signed [PHASE_W+1:0]  period_s;
    logic signed [PHASE_W+1:0]  half_s;
    logic signed [PHASE_W+1:0]  step;
    logic signed [PHASE_W+1:0]  drift_nx;
    logic [PHASE_W+1:0]         mag;
    logic [RAW_W-1:0]           enc_sym;

    // ----------------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------------
    // Data is synchronised alongside its clock so both see the same delay.
    assign pins = '{rst_n:   tx_path_reset_n_in,
                    in_clk:  tx_input_clock_in,
                    ref_clk: char_ref_clock_in,
                    raw:     {tx_ctl_in, tx_char_in}};

    pin_sync #(
        .W($bits(pin_bundle_type))
    ) u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pins_in    (pins),
        .pins_out   (sy)
    );

    assign in_edge   = sy.in_clk & ~st.in_clk_d;
    assign ref_edge  = sy.ref_clk & ~st.ref_d;
    assign fault_now = (st.bstate == BUF_FAULT);
    assign ws_req    = st.enc_en & st.buf_full & (st.buf_word[RAW_W-1:CTL_LSB] == CTL_WSYNC);

    // ----------------------------------------------------------------------
    // Phase tracking
    // ----------------------------------------------------------------------
    // Each step is folded into half a period, so the sum tracks true drift.
    always_comb begin
        period_s = $signed({2'b00, st.ref_period});
        half_s   = $signed({3'b000, st.ref_period[PHASE_W-1:1]});
        step     = $signed({2'b00, st.ref_phase}) - $signed({2'b00, st.last_phase});
        if (step > half_s) begin
            step = step - period_s;
        end else if (step < -half_s) begin
            step = step + period_s;
        end
        drift_nx = st.drift + step;
        mag      = (drift_nx < 0) ? $unsigned(-drift_nx) : $unsigned(drift_nx);
        over     = ({mag, 1'b0} > {1'b0, $unsigned(period_s)});
    end

    tx_symbol_encoder u_enc (
        .enc_en_in    (st.enc_en),
        .fault_in     (fault_now),
        .bist_in      (st.bist_en),
        .fill_in      (~st.buf_full | st.ws_on | ws_req),
        .raw_in       (st.buf_word),
        .bist_word_in (st.lfsr),
        .symbol_out   (enc_sym)
    );

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    always_comb begin
        nx          = st;
        nx.in_clk_d = sy.in_clk;
        nx.ref_d    = sy.ref_clk;
        nx.din_d    = sy.raw;

        if (ref_edge) begin
            nx.ref_period = st.ref_phase + 1'b1;
            nx.ref_phase  = '0;
        end else if (st.ref_phase != '1) begin
            nx.ref_phase = st.ref_phase + 1'b1;
        end

        // The value one sample before the edge is captured, since the host
        // may change its data right after its own clock rises.
        if (in_edge) begin
            nx.hold = st.din_d;
            if (!sy.rst_n) begin
                nx.bstate   = BUF_INIT;
                nx.buf_full = 1'b0;
                nx.drift    = '0;
            end else begin
                case (st.bstate)
                    BUF_INIT: begin
                        nx.centre     = st.ref_phase;
                        nx.last_phase = st.ref_phase;
                        nx.drift      = '0;
                        nx.bstate     = BUF_RUN;
                    end
                    BUF_RUN: begin
                        nx.buf_word   = st.hold;
                        nx.buf_full   = 1'b1;
                        nx.last_phase = st.ref_phase;
                        nx.drift      = drift_nx;
                        if (over) begin
                            nx.bstate = BUF_FAULT;
                        end
                    end
                    BUF_FAULT: begin
                        if (st.enc_en && st.hold[RAW_W-1:CTL_LSB] == CTL_WSYNC) begin
                            nx.centre     = st.ref_phase;
                            nx.last_phase = st.ref_phase;
                            nx.drift      = '0;
                            nx.bstate     = BUF_RUN;
                        end
                    end
                    default: begin
                        nx.bstate = BUF_INIT;
                    end
                endcase
            end
        end

        if (ref_edge) begin
            nx.tx_fault = fault_now;
            nx.sym      = enc_sym;
            nx.shift    = enc_sym;
            if (st.bist_en && !fault_now) begin
                nx.lfsr = {st.lfsr[LFSR_W-2:0],
                           st.lfsr[LFSR_W-1] ^ st.lfsr[LFSR_TAP]};
            end
            if (st.ws_on) begin
                if (st.ws_cnt == WSYNC_LAST) begin
                    nx.ws_on  = 1'b0;
                    nx.ws_cnt = '0;
                end else begin
                    nx.ws_cnt = st.ws_cnt + 4'h1;
                end
            end else if (ws_req && !fault_now && !st.bist_en) begin
                nx.ws_on  = 1'b1;
                nx.ws_cnt = WSYNC_FIRST;
            end
        end else begin
            nx.shift = {1'b0, st.shift[RAW_W-1:1]};
        end
        nx.serial = st.shift[0];

        // Write channel: address and data are taken in either order.
        if (axi_in.awvalid && st.rsp.awready) begin
            nx.aw_got  = 1'b1;
            nx.aw_addr = axi_in.awaddr;
        end
        if (axi_in.wvalid && st.rsp.wready) begin
            nx.w_got = 1'b1;
            nx.wdata = axi_in.wdata;
            nx.wstrb = axi_in.wstrb;
        end
        if (st.rsp.bvalid && axi_in.bready) begin
            nx.rsp.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.rsp.bvalid) begin
            nx.rsp.bvalid = 1'b1;
            nx.rsp.bresp  = RESP_OKAY;
            nx.aw_got     = 1'b0;
            nx.w_got      = 1'b0;
            case (st.aw_addr)
                CTRL_ADDR: begin
                    if (st.wstrb[0]) begin
                        nx.enc_en  = st.wdata[CTRL_ENC_BIT];
                        nx.bist_en = st.wdata[CTRL_BIST_BIT];
                        if (!st.wdata[CTRL_BIST_BIT]) begin
                            nx.lfsr = LFSR_SEED;
                        end
                    end
                end
                STATUS_ADDR, PHASE_ADDR: begin
                    nx.rsp.bresp = RESP_OKAY;
                end
                default: begin
                    nx.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end
        nx.rsp.awready = ~nx.aw_got & ~nx.rsp.bvalid & ~(st.aw_got & st.w_got);
        nx.rsp.wready  = ~nx.w_got & ~nx.rsp.bvalid & ~(st.aw_got & st.w_got);

        if (st.rsp.rvalid && axi_in.rready) begin
            nx.rsp.rvalid = 1'b0;
        end
        if (axi_in.arvalid && st.rsp.arready) begin
            nx.rsp.rvalid = 1'b1;
            nx.rsp.rdata  = '0;
            nx.rsp.rresp  = RESP_OKAY;
            case (axi_in.araddr)
                CTRL_ADDR: begin
                    nx.rsp.rdata[CTRL_ENC_BIT]  = st.enc_en;
                    nx.rsp.rdata[CTRL_BIST_BIT] = st.bist_en;
                end
                STATUS_ADDR: begin
                    nx.rsp.rdata[ST_FAULT_BIT] = st.tx_fault;
                    nx.rsp.rdata[ST_WSYNC_BIT] = st.ws_on;
                    nx.rsp.rdata[ST_READY_BIT] = st.buf_full;
                end
                PHASE_ADDR: begin
                    nx.rsp.rdata[PHASE_W-1:0] = st.centre;
                end
                default: begin
                    nx.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end
        nx.rsp.arready = ~nx.rsp.rvalid;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st             <= '0;
            st.bstate      <= BUF_INIT;
            st.lfsr        <= LFSR_SEED;
            st.enc_en      <= CTRL_ENC_RST;
            st.bist_en     <= CTRL_BIST_RST;
            st.rsp.awready <= 1'b1;
            st.rsp.wready  <= 1'b1;
            st.rsp.arready <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    assign axi_out             = st.rsp;
    assign tx_symbol_out       = st.sym;
    assign tx_serial_out       = st.serial;
    assign tx_fault_flag_out   = st.tx_fault;
    assign tx_wsync_active_out = st.ws_on;

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence fault_entry_s;
        in_edge && sy.rst_n && st.bstate == BUF_RUN && over;
    endsequence

    sequence wsync_start_s;
        ref_edge && !st.ws_on && ws_req && !fault_now && !st.bist_en;
    endsequence

    sequence wsync_mid_s;
        ref_edge && st.ws_on && st.ws_cnt != WSYNC_LAST;
    endsequence

    capture_reg_a: assert property (
        in_edge |=> st.hold == $past(st.din_d))
        else $error("Input register missed a character.");

    bypass_map_a: assert property (
        ref_edge && !fault_now && !st.bist_en && st.buf_full && !st.enc_en
        |=> st.sym == $past(st.buf_word))
        else $error("Bypassed character was altered.");

    lsb_first_a: assert property (
        ref_edge |=> ##1 tx_serial_out == st.sym[0])
        else $error("Serial output did not start with bit zero.");

    buffer_init_a: assert property (
        in_edge && !sy.rst_n |=> st.bstate == BUF_INIT && !st.buf_full)
        else $error("Buffer not initialised by low reset sample.");

    centre_set_a: assert property (
        in_edge && sy.rst_n && st.bstate == BUF_INIT
        |=> st.bstate == BUF_RUN && st.centre == $past(st.ref_phase))
        else $error("Centre phase not recorded on reset release.");

    fault_entry_a: assert property (
        fault_entry_s |=> st.bstate == BUF_FAULT)
        else $error("Excess skew did not raise the buffer fault.");

    flag_domain_a: assert property (
        !ref_edge |=> $stable(tx_fault_flag_out))
        else $error("Fault output changed off a reference edge.");

    violation_out_a: assert property (
        ref_edge && fault_now |=> st.sym == VIOL_SYM && tx_fault_flag_out)
        else $error("Fault did not force the violation symbol.");

    recentre_a: assert property (
        in_edge && sy.rst_n && fault_now && st.enc_en
        && st.hold[RAW_W-1:CTL_LSB] == CTL_WSYNC
        |=> st.bstate == BUF_RUN && st.drift == 0)
        else $error("Word sync did not recentre the buffer.");

    wsync_start_a: assert property (
        wsync_start_s |=> st.ws_on && st.ws_cnt == WSYNC_FIRST
        && st.sym == COMMA_SYM)
        else $error("Word sync did not start with a comma.");

    wsync_run_a: assert property (
        wsync_mid_s |=> st.ws_on && st.ws_cnt == $past(st.ws_cnt) + 4'h1)
        else $error("Word sync ended before sixteen characters.");

    bist_prio_a: assert property (
        ref_edge && st.bist_en && !fault_now |=> st.sym == {1'b0, $past(st.lfsr)})
        else $error("Self-test pattern lost its priority.");

endmodule

// file: dv/host_model.sv
// Purpose: Host side of one channel: input clock, characters, path reset.
// Assumes: The bench offers one ten-bit word per input clock.
// Notes:   Pins change on the falling edge, half a character before capture.
`timescale 1ns/1ps
module host_model (
    input  wire logic       hold_rst_in,
    input  wire logic [9:0] word_in,
    output logic            hclk_out,
    output logic            rst_n_out,
    output logic [9:0]      pins_out,
    output logic            sent_out
);
    logic [1:0] cnt;
    initial begin
        hclk_out = 1'b0;
        rst_n_out = 1'b0;
        pins_out = 10'h1bc;
        sent_out = 1'b0;
        cnt = 2'h2;
    end
    always #16 hclk_out = ~hclk_out;
    // A short request still spans three rising edges, so every channel resets.
    always @(negedge hclk_out) begin
        pins_out <= word_in;
        sent_out <= ~sent_out;
        cnt <= hold_rst_in ? 2'h2 : ((cnt != 2'h0) ? cnt - 2'h1 : cnt);
        rst_n_out <= !hold_rst_in && cnt == 2'h0;
    end
endmodule

// file: dv/tx_align_encode_tb_top.sv
// Purpose: Self-checking bench for the transmit align and encode channel.
// Assumes: Input and reference clocks run at 32 ns, system clock at 4 ns.
// Notes:   Expected symbols are queued as the host launches characters.
`timescale 1ns/1ps
module tx_align_encode_tb_top;
    import tx_pkg::*;
    logic        clk_in = 1'b0, sys_rst = 1'b1, ref_clk = 1'b0, hold_rst = 1'b1;
    logic        nxt_chk = 1'b0, hclk, prst_n, sent, ser, flt, ws;
    logic [9:0]  word = 10'h1bc, last_sym = 10'h1bc, nxt_exp, last_exp, w, x, es, pins, sym;
    logic [9:0]  bs;
    logic [33:0] be;
    realtime     ref_half = 16;
    int          mode = 0, miscompares = 0, n_checks = 0, seed_v;
    axi_req_type req = '0;
    axi_rsp_type rsp;
    logic [9:0]  sq[$];
    logic [33:0] bq[$];
    host_model host_u (.hold_rst_in(hold_rst), .word_in(word), .hclk_out(hclk),
        .rst_n_out(prst_n), .pins_out(pins), .sent_out(sent));
    tx_align_encode dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst), .tx_input_clock_in(hclk),
        .char_ref_clock_in(ref_clk), .tx_path_reset_n_in(prst_n), .tx_char_in(pins[7:0]),
        .tx_ctl_in(pins[9:8]), .axi_in(req), .axi_out(rsp), .tx_symbol_out(sym),
        .tx_serial_out(ser), .tx_fault_flag_out(flt), .tx_wsync_active_out(ws));
    always #2 clk_in = ~clk_in;
    initial begin
        #5;
        forever #(ref_half) ref_clk = ~ref_clk;
    end
    task automatic check(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic wc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_in);
        bq.push_back({r, 32'h0});
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_in);
        bq.push_back({r, d});
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
    endtask
    always @(posedge clk_in) begin
        if ((rsp.rvalid & req.rready | rsp.bvalid & req.bready) === 1'b1) begin
            be = bq.pop_front();
            if (req.rready) check({rsp.rresp, rsp.rdata} === be, "read data");
            else check({rsp.bresp, 32'h0} === be, "write response");
        end
    end
    // Successive checked symbols always differ, so each change marks one character.
    always @(sent) begin
        if (nxt_chk) sq.push_back(nxt_exp);
        @(posedge clk_in);
        do begin
            w = 10'($urandom);
            if (mode == 2) w[8] = 1'b0;
            x = (mode == 2) ? {1'b0, w[9], w[7:0]} : w;
        end while (x == last_exp || x == COMMA_SYM || x == VIOL_SYM);
        if (mode == 0) w = COMMA_SYM;
        if (mode == 3) w[9:8] = CTL_WSYNC;
        last_exp = x;
        word <= w;
        nxt_exp <= x;
        nxt_chk <= mode == 1 || mode == 2;
    end
    always @(posedge clk_in) begin
        #1;
        if (sym !== last_sym && sq.size() > 0) begin
            es = sq.pop_front();
            check(sym === es, "symbol");
            for (int i = 0; i < 4; i++) begin
                @(posedge clk_in);
                #1;
                check(ser === es[i], "serial bit");
            end
        end
        last_sym = sym;
    end
    task automatic run(input int m, input int n);
        mode = m;
        wc(n);
        mode = 0;
        wc(8);
        check(sq.size() == 0, "characters lost");
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #30000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        seed_v = $urandom(32'h1bf8d2ea);
        repeat (16) @(posedge clk_in);
        sys_rst <= 1'b0;
        hold_rst <= 1'b0;
        rd(CTRL_ADDR, 32'h1, RESP_OKAY);
        rd(8'h0c, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'h0, RESP_SLVERR);
        wr(CTRL_ADDR, 32'h0, RESP_OKAY);
        rd(CTRL_ADDR, 32'h0, RESP_OKAY);
        run(1, 40);
        wr(CTRL_ADDR, 32'h1, RESP_OKAY);
        run(2, 40);
        ref_half = 18;
        wc(30);
        check(flt === 1'b1 && sym === VIOL_SYM, "fault");
        rd(STATUS_ADDR, 32'h5, RESP_OKAY);
        ref_half = 16;
        wc(20);
        check(flt === 1'b1, "fault sticky");
        mode = 3;
        wc(8);
        check(flt === 1'b0 && ws === 1'b1 && sym === COMMA_SYM, "sync");
        mode = 0;
        wc(24);
        check(ws === 1'b0, "sync end");
        wr(CTRL_ADDR, 32'h2, RESP_OKAY);
        mode = 3;
        wc(4);
        bs = sym;
        wc(1);
        // Each character slot must advance the pattern by exactly one step.
        check(sym === {1'b0, bs[7:0], bs[8] ^ bs[4]}, "self-test");
        wr(CTRL_ADDR, 32'h0, RESP_OKAY);
        hold_rst <= 1'b1;
        wc(4);
        check(sym === COMMA_SYM, "path reset");
        report_and_stop();
    end
endmodule
